// *** core/calib_pkg.sv ***
// constants and types for the read-calibration pattern mode
package calib_pkg;
    localparam int          DQ_W         = 8;
    localparam int          ADDR_W       = 16;
    localparam int          BA_W         = 3;
    localparam int          LAT_W        = 5;
    localparam int          RL_W         = 6;
    localparam int          RL_MAX       = 40;
    localparam logic [BA_W-1:0] MR3_SEL  = 3'h3;
    localparam int          EN_BIT       = 2;
    localparam int          LOC_LSB      = 0;
    localparam int          LOC_W        = 2;
    localparam int          NIB_BIT      = 2;
    localparam int          AP_BIT       = 10;
    localparam int          BC_BIT       = 12;
    localparam int          COL_W        = 10;
    localparam logic [LOC_W-1:0] LOC_ZERO = 2'h0;
    localparam logic [7:0]  PATTERN_LOC0 = 8'hAA;
    localparam logic [7:0]  PATTERN_RFU  = 8'h00;
    localparam logic [1:0]  BL_FIXED8    = 2'h0;
    localparam logic [1:0]  BL_OTF       = 2'h1;
    localparam logic [1:0]  BL_FIXED4    = 2'h2;
    localparam logic [2:0]  LEN8_LAST    = 3'h7;
    localparam logic [2:0]  LEN4_LAST    = 3'h3;

    typedef enum logic [1:0] {
        CMD_OTHER = 2'h0,
        CMD_MRS   = 2'h1,
        CMD_READ  = 2'h3,
        CMD_WRITE = 2'h2
    } cmd_e;

    typedef enum logic {
        MODE_NORMAL  = 1'b0,
        MODE_PATTERN = 1'b1
    } mode_e;

    typedef struct packed {
        logic             valid;
        logic             chop;
        logic             upper;
        logic [LOC_W-1:0] loc;
    } rd_slot_s;
endpackage : calib_pkg

// *** core/burst_if.sv ***
// carrier between the pattern-mode control and the burst generator
`timescale 1ns/100ps
interface burst_if;
    import calib_pkg::*;
    logic             start;
    logic             chop;
    logic             upper;
    logic [LOC_W-1:0] loc;
    logic             beat_valid;
    logic             beat_bit;

    modport ctrl (output start, output chop, output upper, output loc, input beat_valid, input beat_bit);
    modport gen  (input start, input chop, input upper, input loc, output beat_valid, output beat_bit);
endinterface : burst_if

// *** core/pattern_burst.sv ***
// burst generator that walks the selected calibration pattern bit by bit
`timescale 1ns/100ps
module pattern_burst
    import calib_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    burst_if.gen      bus
);
    logic       busy;
    logic       next_busy;
    logic [2:0] pos;
    logic [2:0] next_pos;
    logic [2:0] last;
    logic [2:0] next_last;
    logic [7:0] pat;
    logic [7:0] next_pat;
    logic       vld;
    logic       next_vld;
    logic       bitv;
    logic       next_bitv;

    function automatic logic [7:0] pattern_of(input logic [LOC_W-1:0] loc);
        pattern_of = (loc == LOC_ZERO) ? PATTERN_LOC0 : PATTERN_RFU;
    endfunction : pattern_of

    always_comb begin
        next_busy = busy;
        next_pos  = pos;
        next_last = last;
        next_pat  = pat;
        next_vld  = 1'b0;
        next_bitv = 1'b0;
        if (bus.start) begin
            next_busy = 1'b1;
            next_pat  = pattern_of(bus.loc);
            next_pos  = bus.chop ? {bus.upper, 2'h0} : 3'h0;
            next_last = bus.chop ? {bus.upper, LEN4_LAST[1:0]} : LEN8_LAST;
        end else if (busy) begin
            next_vld  = 1'b1;
            next_bitv = pat[pos];
            if (pos == last) begin
                next_busy = 1'b0;
            end else begin
                next_pos = pos + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
            pos  <= 3'h0;
            last <= 3'h0;
            pat  <= 8'h00;
            vld  <= 1'b0;
            bitv <= 1'b0;
        end else begin
            busy <= next_busy;
            pos  <= next_pos;
            last <= next_last;
            pat  <= next_pat;
            vld  <= next_vld;
            bitv <= next_bitv;
        end
    end

    assign bus.beat_valid = vld;
    assign bus.beat_bit   = bitv;
endmodule : pattern_burst

// *** core/calib_pattern_top.sv ***
// read-calibration pattern mode: command decode, latency line and data drive
`timescale 1ns/100ps
module calib_pattern_top
    import calib_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              cs_n,
    input  wire logic              ras_n,
    input  wire logic              cas_n,
    input  wire logic              we_n,
    input  wire logic [BA_W-1:0]   ba,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [1:0]        burst_mode,
    input  wire logic [LAT_W-1:0]  additive_lat,
    input  wire logic [LAT_W-1:0]  cas_lat,
    input  wire logic              dq_replicate,
    output logic                   pattern_mode,
    output logic [LOC_W-1:0]       pattern_location_field,
    output logic                   array_rd,
    output logic                   array_wr,
    output logic                   array_ap,
    output logic                   array_chop,
    output logic [BA_W-1:0]        array_ba,
    output logic [COL_W-1:0]       array_col,
    output logic [DQ_W-1:0]        dq_out,
    output logic                   dq_oe
);
    burst_if bif ();

    mode_e              mode;
    mode_e              next_mode;
    logic [LOC_W-1:0]   loc;
    logic [LOC_W-1:0]   next_loc;
    logic               a_rd;
    logic               next_a_rd;
    logic               a_wr;
    logic               next_a_wr;
    logic               a_ap;
    logic               next_a_ap;
    logic               a_chop;
    logic               next_a_chop;
    logic [BA_W-1:0]    a_ba;
    logic [BA_W-1:0]    next_a_ba;
    logic [COL_W-1:0]   a_col;
    logic [COL_W-1:0]   next_a_col;
    logic [DQ_W-1:0]    dq;
    logic [DQ_W-1:0]    next_dq;
    logic               oe;
    logic               next_oe;
    rd_slot_s           line      [RL_MAX];
    rd_slot_s           next_line [RL_MAX];
    rd_slot_s           tap;
    logic [RL_W-1:0]    rl_idx;
    cmd_e               cmd;
    logic               chop_now;

    function automatic cmd_e decode(input logic c, input logic r, input logic a, input logic w);
        if (c) begin
            decode = CMD_OTHER;
        end else if (!r && !a && !w) begin
            decode = CMD_MRS;
        end else if (r && !a && w) begin
            decode = CMD_READ;
        end else if (r && !a && !w) begin
            decode = CMD_WRITE;
        end else begin
            decode = CMD_OTHER;
        end
    endfunction : decode

    function automatic logic chop_of(input logic [1:0] m, input logic bc);
        if (m == BL_FIXED4) begin
            chop_of = 1'b1;
        end else if (m == BL_OTF) begin
            chop_of = !bc;
        end else begin
            chop_of = 1'b0;
        end
    endfunction : chop_of

    assign cmd      = decode(cs_n, ras_n, cas_n, we_n);
    assign chop_now = chop_of(burst_mode, addr[BC_BIT]);

    always_comb begin
        logic [RL_W:0] rl_sum;
        rl_sum = {2'h0, additive_lat} + {2'h0, cas_lat};
        if (rl_sum == '0) begin
            rl_idx = '0;
        end else if (rl_sum > (RL_W+1)'(RL_MAX)) begin
            rl_idx = RL_W'(RL_MAX - 1);
        end else begin
            rl_idx = RL_W'(rl_sum - 1'b1);
        end
    end

    assign tap = line[rl_idx];

    // mode register and normal command path
    always_comb begin
        next_mode   = mode;
        next_loc    = loc;
        next_a_rd   = 1'b0;
        next_a_wr   = 1'b0;
        next_a_ap   = 1'b0;
        next_a_chop = a_chop;
        next_a_ba   = a_ba;
        next_a_col  = a_col;
        if (cmd == CMD_MRS && ba == MR3_SEL) begin
            if (addr[EN_BIT]) begin
                next_mode = MODE_PATTERN;
                next_loc  = addr[LOC_LSB +: LOC_W];
            end else begin
                next_mode = MODE_NORMAL;
            end
        end else if (mode == MODE_NORMAL && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
            next_a_rd   = (cmd == CMD_READ);
            next_a_wr   = (cmd == CMD_WRITE);
            next_a_ap   = addr[AP_BIT];
            next_a_chop = chop_now;
            next_a_ba   = ba;
            next_a_col  = addr[COL_W-1:0];
        end
    end

    // read latency line for pattern reads
    always_comb begin
        rd_slot_s s;
        s.valid = (mode == MODE_PATTERN) && (cmd == CMD_READ);
        s.chop  = chop_now;
        s.upper = addr[NIB_BIT];
        s.loc   = loc;
        next_line[0] = s;
        for (int i = 1; i < RL_MAX; i++) begin
            next_line[i] = line[i-1];
        end
    end

    assign bif.start = tap.valid;
    assign bif.chop  = tap.chop;
    assign bif.upper = tap.upper;
    assign bif.loc   = tap.loc;

    pattern_burst u_burst (
        .clk  (clk),
        .rstn (rstn),
        .bus  (bif)
    );

    // data drive
    always_comb begin
        next_oe = bif.beat_valid;
        next_dq = '0;
        if (bif.beat_valid) begin
            next_dq    = dq_replicate ? {DQ_W{bif.beat_bit}} : '0;
            next_dq[0] = bif.beat_bit;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode   <= MODE_NORMAL;
            loc    <= LOC_ZERO;
            a_rd   <= 1'b0;
            a_wr   <= 1'b0;
            a_ap   <= 1'b0;
            a_chop <= 1'b0;
            a_ba   <= '0;
            a_col  <= '0;
            dq     <= '0;
            oe     <= 1'b0;
        end else begin
            mode   <= next_mode;
            loc    <= next_loc;
            a_rd   <= next_a_rd;
            a_wr   <= next_a_wr;
            a_ap   <= next_a_ap;
            a_chop <= next_a_chop;
            a_ba   <= next_a_ba;
            a_col  <= next_a_col;
            dq     <= next_dq;
            oe     <= next_oe;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < RL_MAX; i++) begin
                line[i] <= '0;
            end
        end else begin
            for (int i = 0; i < RL_MAX; i++) begin
                line[i] <= next_line[i];
            end
        end
    end

    assign pattern_mode           = mode;
    assign pattern_location_field = loc;
    assign array_rd               = a_rd;
    assign array_wr               = a_wr;
    assign array_ap               = a_ap;
    assign array_chop             = a_chop;
    assign array_ba               = a_ba;
    assign array_col              = a_col;
    assign dq_out                 = dq;
    assign dq_oe                  = oe;
endmodule : calib_pattern_top

// *** verif/calib_pattern_chk.sv ***
// assertion checker for the calibration pattern mode ports
`timescale 1ns/100ps
module calib_pattern_chk
    import calib_pkg::*;
(
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              cs_n,
    input wire logic              ras_n,
    input wire logic              cas_n,
    input wire logic              we_n,
    input wire logic [BA_W-1:0]   ba,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LAT_W-1:0]  additive_lat,
    input wire logic [LAT_W-1:0]  cas_lat,
    input wire logic              pattern_mode,
    input wire logic [LOC_W-1:0]  pattern_location_field,
    input wire logic              array_rd,
    input wire logic              array_wr,
    input wire logic              array_ap,
    input wire logic [BA_W-1:0]   array_ba,
    input wire logic [DQ_W-1:0]   dq_out,
    input wire logic              dq_oe
);
    logic mrs;
    logic rd;
    logic wr;
    assign mrs = !cs_n && !ras_n && !cas_n && !we_n && ba == MR3_SEL;
    assign rd  = !cs_n && ras_n && !cas_n && we_n;
    assign wr  = !cs_n && ras_n && !cas_n && !we_n;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_mode_enter: assert property (mrs && addr[EN_BIT] |=> pattern_mode)
        else $error("pattern mode not entered");
    a_mode_leave: assert property (mrs && !addr[EN_BIT] |=> !pattern_mode)
        else $error("pattern mode not left");
    a_loc_store: assert property (mrs && addr[EN_BIT] |=> pattern_location_field == $past(addr[1:0]))
        else $error("location not stored");
    a_loc_ignore: assert property (mrs && !addr[EN_BIT] |=> $stable(pattern_location_field))
        else $error("location changed on disable");
    a_pat_no_array: assert property (pattern_mode && (rd || wr) |=> !array_rd && !array_wr && !array_ap)
        else $error("array access in pattern mode");
    a_norm_read: assert property (!pattern_mode && rd |=> array_rd && array_ap == $past(addr[AP_BIT]))
        else $error("normal read not passed to array");
    a_norm_write: assert property (!pattern_mode && wr |=> array_wr && array_ba == $past(ba))
        else $error("normal write not passed to array");
    a_dq_upper: assert property (dq_oe |-> dq_out[7:1] == {7{dq_out[0]}} || dq_out[7:1] == 7'h00)
        else $error("upper data bits wrong");
    a_rl_first: assert property (pattern_mode && rd && additive_lat == 5'h00 && cas_lat == 5'h05 &&
        !addr[NIB_BIT] && pattern_location_field == LOC_ZERO |-> ##8 dq_oe && !dq_out[0] ##1 dq_oe && dq_out[0])
        else $error("first pattern beats wrong");
    a_burst_min: assert property ($rose(dq_oe) |-> dq_oe[*4])
        else $error("burst shorter than four beats");
    a_reset_idle: assert property ($rose(rstn) |-> !pattern_mode && !dq_oe)
        else $error("outputs active after reset");
endmodule : calib_pattern_chk
bind calib_pattern_top calib_pattern_chk u_chk (.*);

// *** verif/mem_ctrl_model.sv ***
// far-side memory controller model driving the command pins
`timescale 1ns/100ps
module mem_ctrl_model
    import calib_pkg::*;
(
    input  wire logic         clk,
    output logic              cs_n,
    output logic              ras_n,
    output logic              cas_n,
    output logic              we_n,
    output logic [BA_W-1:0]   ba,
    output logic [ADDR_W-1:0] addr
);
    initial begin
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        ba = 3'h0;
        addr = 16'h0000;
    end
    // one-cycle command, then nop with scrambled address
    task issue(input logic [3:0] c, input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a);
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = c;
        ba = b;
        addr = {a[15:2], (c == 4'h5) ? 2'h0 : a[1:0]};
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        ba = ~ba;
        addr = ~addr;
    endtask : issue
    task mode_set(input logic en, input logic [1:0] loc);
        repeat (4) @(negedge clk);
        if (en) begin
            issue(4'h2, 3'h0, 16'h0400);
            repeat (4) @(negedge clk);
        end
        issue(4'h0, MR3_SEL, {13'h0000, en, loc});
        repeat (12) @(negedge clk);
    endtask : mode_set
endmodule : mem_ctrl_model

// *** verif/calib_pattern_tb_top.sv ***
// testbench for the read-calibration pattern mode
`timescale 1ns/100ps
module calib_pattern_tb_top
    import calib_pkg::*;
;
    logic              clk, rstn, cs_n, ras_n, cas_n, we_n, dq_replicate, dq_oe;
    logic              pattern_mode, array_rd, array_wr, array_ap, array_chop;
    logic [BA_W-1:0]   ba, array_ba;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        burst_mode, pattern_location_field;
    logic [LAT_W-1:0]  additive_lat, cas_lat;
    logic [COL_W-1:0]  array_col;
    logic [DQ_W-1:0]   dq_out;
    int                n_mismatch, cmp_count, cyc;
    calib_pattern_top dut (.*);
    mem_ctrl_model ctrl (.*);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task t_normal();
        ctrl.issue(4'h5, 3'h5, 16'h0404);
        check("array read", {array_rd, array_ap, array_ba, array_col}, {1'b1, 1'b1, 3'h5, 10'h004});
        check("read chop", array_chop, 1'b0);
        burst_mode = 2'h1;
        ctrl.issue(4'h4, 3'h2, 16'h0013);
        check("array write", {array_wr, array_ap, array_ba, array_col}, {1'b1, 1'b0, 3'h2, 10'h013});
        check("write chop", array_chop, 1'b1);
        burst_mode = 2'h0;
    endtask : t_normal
    task t_burst(input logic [1:0] bm, input logic [ADDR_W-1:0] a, input int beats, input logic [7:0] pat);
        int n;
        logic [2:0] pos;
        burst_mode = bm;
        ctrl.issue(4'h5, 3'h6, a);
        check("no array", {array_rd, array_ap}, 2'h0);
        n = 0;
        while (dq_oe !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        check("latency", n, additive_lat + cas_lat + 2);
        pos = (a[NIB_BIT] && beats == 4) ? 3'h4 : 3'h0;
        repeat (beats) begin
            check("beat", {dq_oe, dq_out}, {1'b1, pat[pos] ? (dq_replicate ? 8'hFF : 8'h01) : 8'h00});
            pos++;
            @(negedge clk);
        end
        check("burst end", dq_oe, 1'b0);
        repeat (4) @(negedge clk);
    endtask : t_burst
    task t_pattern();
        ctrl.mode_set(1'b1, 2'h0);
        check("mode on", {pattern_mode, pattern_location_field}, 3'h4);
        t_burst(2'h0, 16'hFFF8, 8, 8'hAA);
        t_burst(2'h2, 16'h0000, 4, 8'hAA);
        t_burst(2'h2, 16'h0004, 4, 8'hAA);
        t_burst(2'h1, 16'h0004, 4, 8'hAA);
        t_burst(2'h1, 16'h1000, 8, 8'hAA);
        t_burst(2'h3, 16'h0000, 8, 8'hAA);
        dq_replicate = 1'b0;
        t_burst(2'h0, 16'h0000, 8, 8'hAA);
        dq_replicate = 1'b1;
        ctrl.mode_set(1'b0, 2'h0);
        ctrl.mode_set(1'b1, 2'h1);
        t_burst(2'h0, 16'h0000, 8, 8'h00);
        ctrl.mode_set(1'b0, 2'h3);
        check("mode off", {pattern_mode, pattern_location_field}, 3'h1);
        t_normal();
    endtask : t_pattern
    task t_reset();
        ctrl.mode_set(1'b1, 2'h0);
        burst_mode = 2'h0;
        ctrl.issue(4'h5, 3'h0, 16'h0000);
        repeat (additive_lat + cas_lat + 3) @(negedge clk);
        check("mid burst", dq_oe, 1'b1);
        rstn = 1'b0;
        #1;
        check("reset", {pattern_mode, dq_oe, dq_out}, 10'h000);
        @(negedge clk);
        rstn = 1'b1;
        t_normal();
    endtask : t_reset
    initial begin
        rstn = 1'b0;
        burst_mode = 2'h0;
        additive_lat = 5'h00;
        cas_lat = 5'h05;
        dq_replicate = 1'b1;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        t_normal();
        t_pattern();
        t_reset();
        end_of_test();
    end
endmodule : calib_pattern_tb_top
